/* logic/crsc_pkg.sv */
// Package of shared constants for the crank sensor conditioner.
`default_nettype none
package crsc_pkg;
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [4:0] OFS_RUN   = 5'h00;
	localparam logic [4:0] OFS_CRANK = 5'h04;
	localparam logic [4:0] OFS_MISC  = 5'h08;
	localparam logic [4:0] OFS_DECAY = 5'h0C;
	localparam logic [4:0] OFS_STAT  = 5'h10;
	localparam logic [4:0] OFS_WIDTH = 5'h14;
	// Reset values.
	localparam logic [7:0]  RST_RUN   = 8'h50;
	localparam logic [7:0]  RST_CRANK = 8'h00;
	localparam logic [7:0]  RST_MISC  = 8'h00;
	localparam logic [15:0] RST_DECAY = 16'h0100;
	// Parameter register fields.
	localparam int THR_MSB = 7;
	localparam int THR_LSB = 4;
	localparam int BLK_MSB = 3;
	localparam int BLK_LSB = 0;
	// Miscellaneous register bit positions.
	localparam int MISC_AUTO  = 7;
	localparam int MISC_DIS   = 6;
	localparam int MISC_LOREF = 5;
	localparam int MISC_SE    = 4;
	localparam int MISC_DEGL  = 3;
	localparam int MISC_TDMSB = 2;
	// Blanking step is one thirty-second of the reference pulse.
	localparam logic [3:0] BLK_SHIFT  = 4'h5;
	// Deglitch window is five five-hundred-twelfths, close to one percent.
	localparam logic [3:0] DEGL_MULT  = 4'h5;
	localparam logic [3:0] DEGL_SHIFT = 4'h9;
	localparam logic [3:0] THR_MAX    = 4'hF;
	typedef enum logic [1:0] {
		ST_MANUAL = 2'b00,
		ST_MAX    = 2'b01,
		ST_DECAY  = 2'b11
	} crsc_auto_t;
endpackage : crsc_pkg
`default_nettype wire

/* logic/crsc_pulse_meter.sv */
// Measures the last high and low durations of a logic level.
`timescale 1ns/1ps
`default_nettype none
module crsc_pulse_meter
	import crsc_pkg::*;
#(
	parameter int CNT_W = 16
)(
	// Clock, reset and clock enable.
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	// Measured level and results.
	input  wire logic             level,
	output logic      [CNT_W-1:0] high_w,
	output logic      [CNT_W-1:0] low_w
);
	logic             prev_reg;
	logic [CNT_W-1:0] cnt_reg;
	wire              edge_seen = level != prev_reg;
	wire              cnt_full  = &cnt_reg;

	// Counter saturates so a stalled wheel reads as the longest pulse.
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			prev_reg <= 1'b0;
			cnt_reg  <= '0;
			high_w   <= '0;
			low_w    <= '0;
		end
		else if (ce)
		begin
			prev_reg <= level;
			if (edge_seen)
				cnt_reg <= CNT_W'(1);
			else if (!cnt_full)
				cnt_reg <= cnt_reg + CNT_W'(1);
			if (edge_seen && !level)
				high_w <= cnt_reg;
			if (edge_seen && level)
				low_w <= cnt_reg;
		end
endmodule : crsc_pulse_meter
`default_nettype wire

/* logic/crsc_top.sv */
// Crank sensor conditioner: parameter sets, deglitch, blanking and tachometer.
`timescale 1ns/1ps
`default_nettype none
module crsc_top
	import crsc_pkg::*;
#(
	parameter int CNT_W = 16
)(
	// Clock, reset and clock enable.
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// Avalon-MM slave.
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Analog front end.
	input  wire logic        comp_in,
	input  wire logic        zero_cross,
	input  wire logic        sensor_logic_in,
	output logic      [3:0]  threshold_code,
	output logic             single_ended_select,
	output logic             path_disable,
	// Outputs to the host.
	output logic             crank_pulse_out,
	output logic             tachometer_out
);
	function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] w,
		input logic [3:0] m, input logic [3:0] sh);
		logic [CNT_W+3:0] p;
		p = {4'h0, w} * {{CNT_W{1'b0}}, m};
		return CNT_W'(p >> sh);
	endfunction : scale

	logic [7:0]       run_reg;
	logic [7:0]       crank_reg;
	logic [7:0]       misc_reg;
	logic [15:0]      decay_reg;
	logic             ack_reg;
	logic [31:0]      rdata_reg;
	crsc_auto_t       st_reg;
	crsc_auto_t       st_next;
	logic [3:0]       athr_reg;
	logic [3:0]       athr_next;
	logic [15:0]      dcnt_reg;
	logic             cand_reg;
	logic [CNT_W-1:0] stab_reg;
	logic             filt_reg;
	logic [CNT_W-1:0] blank_reg;
	logic             out_reg;
	logic [2:0]       tcnt_reg;
	logic             tach_reg;
	logic [CNT_W-1:0] high_w;
	logic [CNT_W-1:0] low_w;

	// Bus decode.
	wire req      = avs_read || avs_write;
	wire acc      = req && ack_reg;
	wire wr_run   = acc && avs_write && avs_address == OFS_RUN;
	wire wr_crank = acc && avs_write && avs_address == OFS_CRANK;
	wire wr_misc  = acc && avs_write && avs_address == OFS_MISC;
	wire wr_decay = acc && avs_write && avs_address == OFS_DECAY;

	// Active parameter set.
	wire       crank_act = crank_reg != 8'h00;
	wire [7:0] eff_code  = crank_act ? crank_reg : run_reg;
	wire [3:0] sel_thr   = eff_code[THR_MSB:THR_LSB];
	wire [3:0] blk_code  = eff_code[BLK_MSB:BLK_LSB];
	wire       auto_en   = misc_reg[MISC_AUTO];
	wire       lo_ref    = misc_reg[MISC_LOREF];
	wire       degl_en   = misc_reg[MISC_DEGL];
	wire [2:0] tdiv      = misc_reg[MISC_TDMSB:0];

	// Windows from the latest measurements.
	wire [CNT_W-1:0] ref_w       = lo_ref ? low_w : high_w;
	wire [CNT_W:0]   per_sum     = {1'b0, high_w} + {1'b0, low_w};
	wire [CNT_W-1:0] period_w    = per_sum[CNT_W] ? '1 : per_sum[CNT_W-1:0];
	wire [CNT_W-1:0] blank_len   = scale(ref_w, blk_code, BLK_SHIFT);
	wire [CNT_W-1:0] degl_len    = scale(period_w, DEGL_MULT, DEGL_SHIFT);

	// Input path.
	wire raw       = path_disable ? sensor_logic_in : comp_in;
	wire stab_full = &stab_reg;
	wire stable_ok = cand_reg == raw && stab_reg >= degl_len;
	wire filt      = degl_en ? filt_reg : raw;
	wire blanking  = blank_reg != '0;
	wire take_edge = !blanking && filt != out_reg;

	// Tachometer divider: code 0 keeps the output low, else toggles every tdiv rises.
	wire out_rise  = take_edge && filt;
	wire tach_wrap = tcnt_reg + 3'h1 >= tdiv;

	// Auto threshold decay.
	wire dec_done = dcnt_reg >= decay_reg;
	always_comb
	begin
		st_next   = st_reg;
		athr_next = athr_reg;
		case (st_reg)
			ST_MANUAL:
				if (auto_en && zero_cross)
				begin
					st_next   = ST_MAX;
					athr_next = THR_MAX;
				end
			ST_MAX:
				if (dec_done)
					st_next = ST_DECAY;
			ST_DECAY:
				if (!auto_en || athr_reg <= sel_thr)
					st_next = ST_MANUAL;
				else if (dec_done)
					athr_next = athr_reg - 4'h1;
			default:
				st_next = ST_MANUAL;
		endcase
	end

	wire [31:0] rd_mux =
		avs_address == OFS_RUN   ? {24'h0, run_reg} :
		avs_address == OFS_CRANK ? {24'h0, crank_reg} :
		avs_address == OFS_MISC  ? {24'h0, misc_reg} :
		avs_address == OFS_DECAY ? {16'h0, decay_reg} :
		avs_address == OFS_STAT  ? {20'h0, threshold_code, eff_code[3:0],
			st_reg, crank_act, out_reg} :
		avs_address == OFS_WIDTH ? {16'(low_w), 16'(high_w)} : 32'h0;

	// One wait state, then the access completes.
	assign avs_waitrequest     = req && !ack_reg;
	assign avs_readdata        = rdata_reg;
	assign threshold_code      = st_reg == ST_MANUAL ? sel_thr : athr_reg;
	assign single_ended_select = misc_reg[MISC_SE];
	assign path_disable        = misc_reg[MISC_DIS];
	assign crank_pulse_out     = out_reg;
	assign tachometer_out      = tach_reg;

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0;
		end
		else if (ce)
		begin
			ack_reg   <= req && !ack_reg;
			rdata_reg <= (req && !ack_reg) ? rd_mux : rdata_reg;
		end

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			run_reg   <= RST_RUN;
			crank_reg <= RST_CRANK;
			misc_reg  <= RST_MISC;
			decay_reg <= RST_DECAY;
		end
		else if (ce)
		begin
			if (wr_run)
				run_reg <= avs_writedata[7:0];
			if (wr_crank)
				crank_reg <= avs_writedata[7:0];
			if (wr_misc)
				misc_reg <= avs_writedata[7:0];
			if (wr_decay)
				decay_reg <= avs_writedata[15:0];
		end

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			st_reg   <= ST_MANUAL;
			athr_reg <= THR_MAX;
			dcnt_reg <= 16'h0;
		end
		else if (ce)
		begin
			st_reg   <= st_next;
			athr_reg <= athr_next;
			dcnt_reg <= (st_next != st_reg || dec_done) ? 16'h0 : dcnt_reg + 16'h1;
		end

	// Deglitch needs the level to hold for the whole window before it passes.
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			cand_reg <= 1'b0;
			stab_reg <= '0;
			filt_reg <= 1'b0;
		end
		else if (ce)
		begin
			cand_reg <= raw;
			if (cand_reg != raw)
				stab_reg <= '0;
			else if (!stab_full)
				stab_reg <= stab_reg + CNT_W'(1);
			if (stable_ok)
				filt_reg <= cand_reg;
		end

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			out_reg   <= 1'b0;
			blank_reg <= '0;
		end
		else if (ce)
		begin
			if (take_edge)
			begin
				out_reg   <= filt;
				blank_reg <= blank_len;
			end
			else if (blanking)
				blank_reg <= blank_reg - CNT_W'(1);
		end

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			tcnt_reg <= 3'h0;
			tach_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (tdiv == 3'h0)
			begin
				tcnt_reg <= 3'h0;
				tach_reg <= 1'b0;
			end
			else if (out_rise)
			begin
				tcnt_reg <= tach_wrap ? 3'h0 : tcnt_reg + 3'h1;
				tach_reg <= tach_wrap ? !tach_reg : tach_reg;
			end
		end

	// Measures the conditioned output, so blanked noise never shortens a window.
	crsc_pulse_meter #(
		.CNT_W (CNT_W)
	) u_meter (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.level   (out_reg),
		.high_w  (high_w),
		.low_w   (low_w)
	);

	property p_sel_run;
		@(posedge ref_clk) disable iff (sys_rst)
		crank_reg == 8'h00 |-> threshold_code == run_reg[7:4] || st_reg != ST_MANUAL;
	endproperty
	a_sel_run: assert property (p_sel_run) else $error("running set not applied");

	property p_sel_crank;
		@(posedge ref_clk) disable iff (sys_rst)
		crank_reg != 8'h00 && st_reg == ST_MANUAL |-> threshold_code == crank_reg[7:4];
	endproperty
	a_sel_crank: assert property (p_sel_crank) else $error("cranking set not applied");

	property p_auto_max;
		@(posedge ref_clk) disable iff (sys_rst)
		ce && auto_en && zero_cross && st_reg == ST_MANUAL |=> threshold_code == 4'hF;
	endproperty
	a_auto_max: assert property (p_auto_max) else $error("auto did not jump to max");

	property p_blank_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		blanking |=> $stable(out_reg);
	endproperty
	a_blank_hold: assert property (p_blank_hold) else $error("output moved while blanked");

	property p_blank_load;
		@(posedge ref_clk) disable iff (sys_rst)
		$changed(out_reg) |-> blank_reg == $past(blank_len);
	endproperty
	a_blank_load: assert property (p_blank_load) else $error("blanking not started");

	property p_ref_sel;
		@(posedge ref_clk) disable iff (sys_rst)
		lo_ref && blk_code == 4'h8 |-> blank_len == CNT_W'(low_w >> 2);
	endproperty
	a_ref_sel: assert property (p_ref_sel) else $error("low reference not used");

	property p_bypass;
		@(posedge ref_clk) disable iff (sys_rst)
		ce && path_disable && !degl_en && !blanking && sensor_logic_in
			|=> crank_pulse_out;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass input not passed");

	property p_tach_off;
		@(posedge ref_clk) disable iff (sys_rst)
		ce && tdiv == 3'h0 |=> !tachometer_out;
	endproperty
	a_tach_off: assert property (p_tach_off) else $error("tachometer not held off");

	property p_bus_wait;
		@(posedge ref_clk) disable iff (sys_rst)
		ce && req && avs_waitrequest |=> !ce || !avs_waitrequest;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus answer late");

	property p_blank_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		ce && take_edge && blk_code == 4'h0 |=> !blanking;
	endproperty
	a_blank_zero: assert property (p_blank_zero) else $error("code zero still blanks");

	// A stalled enable must also stall the blanking count, or windows would shrink.
	property p_ce_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		!ce |=> $stable(out_reg) && $stable(blank_reg) && $stable(tach_reg);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved while disabled");

	c_blank: cover property (@(posedge ref_clk) disable iff (sys_rst) take_edge && blank_len > 2);
	c_decay: cover property (@(posedge ref_clk) disable iff (sys_rst)
		st_reg == ST_DECAY ##1 st_reg == ST_MANUAL);
	c_crank: cover property (@(posedge ref_clk) disable iff (sys_rst) crank_act && tach_reg);
	c_frozen: cover property (@(posedge ref_clk) disable iff (sys_rst) !ce && filt != out_reg);
endmodule : crsc_top
`default_nettype wire

/* dv/crsc_host_model.sv */
// Host-side model that counts crank pulses and tachometer toggles.
`timescale 1ns/1ps
`default_nettype none
module crsc_host_model
	import crsc_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Pins from the conditioner.
	input  wire logic        crank_pulse_out,
	input  wire logic        tachometer_out,
	// Running counts.
	output logic      [15:0] crank_rises,
	output logic      [15:0] tach_toggles
);
	logic crank_d;
	logic tach_d;
	// The host only sees logic levels, so edges are found on its own clock.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			crank_d      <= 1'b0;
			tach_d       <= 1'b0;
			crank_rises  <= 16'h0000;
			tach_toggles <= 16'h0000;
		end
		else
		begin
			crank_d <= crank_pulse_out;
			tach_d  <= tachometer_out;
			if (crank_pulse_out && !crank_d)
				crank_rises <= crank_rises + 16'h0001;
			if (tachometer_out != tach_d)
				tach_toggles <= tach_toggles + 16'h0001;
		end
	end
endmodule : crsc_host_model
`default_nettype wire

/* dv/tb_crank_sensor_conditioner.sv */
// Testbench for the crank sensor conditioner.
`timescale 1ns/1ps
`default_nettype none
module tb_crank_sensor_conditioner
	import crsc_pkg::*;
;
	logic        ref_clk;
	logic        sys_rst;
	logic        ce;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        comp_in;
	logic        zero_cross;
	logic        sensor_logic_in;
	logic [3:0]  threshold_code;
	logic        single_ended_select;
	logic        path_disable;
	logic        crank_pulse_out;
	logic        tachometer_out;
	logic [15:0] crank_rises;
	logic [15:0] tach_toggles;
	logic [15:0] c0;
	logic [15:0] t0;
	logic [31:0] rd;
	int          n_errors;
	int          checks_done;

	crsc_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .comp_in(comp_in), .zero_cross(zero_cross),
		.sensor_logic_in(sensor_logic_in), .threshold_code(threshold_code),
		.single_ended_select(single_ended_select), .path_disable(path_disable),
		.crank_pulse_out(crank_pulse_out), .tachometer_out(tachometer_out));

	crsc_host_model host (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.crank_pulse_out(crank_pulse_out), .tachometer_out(tachometer_out),
		.crank_rises(crank_rises), .tach_toggles(tach_toggles));

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task end_of_test();
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task fail_wait();
		n_errors++;
		$display("ERROR wait expected done seen timeout");
		end_of_test();
	endtask : fail_wait

	// A request is held until waitrequest is sampled low, for at most 40 cycles before the wait fails.
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		int i;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= wd;
		for (i = 0; i < 40; i++)
		begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (i == 40)
			fail_wait();
		@(posedge ref_clk);
	endtask : bus

	task rdx(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check("register", rd, exp);
	endtask : rdx

	task wait_thr(input logic [3:0] e, input int bound);
		int i;
		for (i = 0; i < bound; i++)
		begin
			@(posedge ref_clk);
			if (threshold_code === e)
				break;
		end
		if (i == bound)
			fail_wait();
		check("threshold", 32'(threshold_code), 32'(e));
	endtask : wait_thr

	task pulses(input int hi, input int lo, input int n);
		repeat (n)
		begin
			comp_in <= 1'b1;
			repeat (hi) @(posedge ref_clk);
			comp_in <= 1'b0;
			repeat (lo) @(posedge ref_clk);
		end
	endtask : pulses

	// Holds the input at base, flips it for g cycles, and notes any output change.
	task glitch(input logic base, input int pre, input int g, input logic shows);
		logic seen;
		int   i;
		seen = 1'b0;
		comp_in <= base;
		for (i = 0; i < pre + g + 5; i++)
		begin
			@(posedge ref_clk);
			if (i > 1 && crank_pulse_out !== base)
				seen = 1'b1;
			if (i == pre)
				comp_in <= ~base;
			if (i == pre + g)
				comp_in <= base;
		end
		check("glitch", 32'(seen), 32'(shows));
	endtask : glitch

	initial
	begin
		sys_rst = 1'b1;
		ce = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		comp_in = 1'b0;
		zero_cross = 1'b0;
		sensor_logic_in = 1'b0;
		n_errors = 0;
		checks_done = 0;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		check("threshold", 32'(threshold_code), 32'h5);
		rdx(OFS_RUN, 32'(RST_RUN));
		rdx(OFS_CRANK, 32'h0);
		rdx(OFS_DECAY, 32'(RST_DECAY));
		rdx(5'h18, 32'h0);
		bus(1'b1, OFS_RUN, 32'h3A);
		check("threshold", 32'(threshold_code), 32'h3);
		bus(1'b1, OFS_CRANK, 32'h01);
		check("threshold", 32'(threshold_code), 32'h0);
		rdx(OFS_STAT, 32'h12);
		bus(1'b1, OFS_CRANK, 32'h00);
		check("threshold", 32'(threshold_code), 32'h3);
		bus(1'b1, OFS_MISC, 32'h50);
		check("disable", 32'(path_disable), 32'h1);
		check("single", 32'(single_ended_select), 32'h1);
		sensor_logic_in <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check("crank", 32'(crank_pulse_out), 32'h1);
		sensor_logic_in <= 1'b0;
		bus(1'b1, OFS_MISC, 32'h00);
		bus(1'b1, OFS_RUN, 32'h30);
		@(posedge ref_clk);
		comp_in <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check("crank", 32'(crank_pulse_out), 32'h1);
		glitch(1'b1, 6, 3, 1'b1);
		// A short low reference gives a short window, so the glitch gets through.
		bus(1'b1, OFS_RUN, 32'h38);
		bus(1'b1, OFS_MISC, 32'h20);
		pulses(64, 8, 3);
		glitch(1'b1, 6, 3, 1'b1);
		bus(1'b1, OFS_MISC, 32'h00);
		pulses(64, 64, 3);
		rdx(OFS_WIDTH, {16'd64, 16'd64});
		glitch(1'b1, 6, 3, 1'b0);
		bus(1'b1, OFS_RUN, 32'h30);
		bus(1'b1, OFS_MISC, 32'h08);
		pulses(600, 600, 2);
		glitch(1'b0, 6, 3, 1'b0);
		bus(1'b1, OFS_MISC, 32'h02);
		c0 = crank_rises;
		t0 = tach_toggles;
		pulses(20, 20, 6);
		check("rises", 32'(crank_rises - c0), 32'h6);
		check("tach", 32'(tach_toggles - t0), 32'h3);
		check("tach", 32'(tachometer_out), 32'h1);
		bus(1'b1, OFS_MISC, 32'h00);
		repeat (2) @(posedge ref_clk);
		check("tach", 32'(tachometer_out), 32'h0);
		// With the clock enable low the output must not follow the input.
		ce      <= 1'b0;
		comp_in <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("frozen", 32'(crank_pulse_out), 32'h0);
		ce <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check("crank", 32'(crank_pulse_out), 32'h1);
		comp_in <= 1'b0;
		bus(1'b1, OFS_DECAY, 32'h4);
		bus(1'b1, OFS_MISC, 32'h80);
		@(posedge ref_clk);
		zero_cross <= 1'b1;
		@(posedge ref_clk);
		zero_cross <= 1'b0;
		wait_thr(THR_MAX, 4);
		wait_thr(4'h3, 300);
		end_of_test();
	end
endmodule : tb_crank_sensor_conditioner
`default_nettype wire
